// ### include/dctp_pkg.sv
// Behaviour
// - Counter decrements once per rising edge of selected prescaler tap; software loads/reads it.
// - Counter decrementing to zero sets the zero flag.
// - Zero with interrupt enable set raises a timer interrupt request.
// - Prescaler input is internal clock divided by 12 or the timer pin.
// - Factor one uses prescaler input; factor two bit 0; factor four bit 1.
// - Run bit one counts; run bit zero forces prescaler all ones, counter stops.
// - With run bit set, software may load any prescaler value 0 to 7Fh.
// - Direction and data bits select event, gated or output mode.
// - Gated mode counts divided internal clock only while timer pin is high.
// - Event mode uses timer pin rising edges as prescaler clock.
// - Output mode uses divided internal clock and drives pin from output latch.
// - Output latch is transparent while zero flag high, holds when it falls.
// - Writing 00h to counter or setting control bit 7 also sets zero flag.
// - Reset loads counter FFh, prescaler 7Fh, clears control; timer stopped.
// - Counter write coinciding with decrement to zero wins; flag stays clear.
// - Counter and prescaler read accurately at any time.
package dctp_pkg;
  localparam int          DCTP_CNT_W      = 8;
  localparam int          DCTP_PSC_W      = 7;
  localparam int          DCTP_FINT_DIV   = 12;
  localparam logic [7:0]  DCTP_CNT_RST    = 8'h00_FF;
  localparam logic [6:0]  DCTP_PSC_RST    = 7'h00_7F;
  localparam logic [7:0]  DCTP_CNT_ZERO   = 8'h00_00;
  // Register byte addresses.
  localparam logic [11:0] DCTP_ADDR_CNT   = 12'h0_000;
  localparam logic [11:0] DCTP_ADDR_PSC   = 12'h0_004;
  localparam logic [11:0] DCTP_ADDR_CTRL  = 12'h0_008;
  localparam logic [11:0] DCTP_ADDR_IRQS  = 12'h0_00C;
  localparam logic [11:0] DCTP_ADDR_IRQM  = 12'h0_010;
  // Control field positions.
  localparam int          DCTP_B_ZERO     = 7;
  localparam int          DCTP_B_ZIE      = 6;
  localparam int          DCTP_B_DIR      = 5;
  localparam int          DCTP_B_DATA     = 4;
  localparam int          DCTP_B_RUN      = 3;
  localparam int          DCTP_B_TAP      = 0;
  localparam int          DCTP_TAP_W      = 3;
  // Interrupt status bits.
  localparam int          DCTP_EV_ZERO    = 0;
  localparam int          DCTP_EV_PINEDGE = 1;
  localparam int          DCTP_EV_W       = 2;

  typedef enum logic [1:0]
  {
    DCTP_MODE_EVENT  = 2'b00,
    DCTP_MODE_GATED  = 2'b01,
    DCTP_MODE_OUTPUT = 2'b10
  } dctp_mode_t;

  typedef struct packed
  {
    logic                  zero_flag;
    logic                  zero_irq_enable;
    logic                  pin_direction_out;
    logic                  pin_data;
    logic                  prescaler_run;
    logic [DCTP_TAP_W-1:0] tap_select;
  } dctp_ctrl_t;
endpackage : dctp_pkg

// ### hdl/dctp_timer.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module dctp_timer
  import dctp_pkg::*;
#(
  parameter int FINT_DIV = DCTP_FINT_DIV
)
(
  // Clock and reset.
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Timer pin.
  input  wire logic        timer_pin_in,
  output logic             timer_pin_out,
  output logic             timer_pin_oe_out,
  // Interrupts.
  output logic             timer_irq_out,
  output logic             irq_out
);

  dctp_ctrl_t                ctrl_reg;
  logic [DCTP_CNT_W-1:0]     down_counter_reg;
  logic [DCTP_PSC_W-1:0]     prescaler_value_reg;
  logic [3:0]                div_reg;
  logic                      fint_tick;
  logic                      pin_prev_reg;
  logic                      pin_rise;
  logic                      psc_tick;
  logic [DCTP_PSC_W-1:0]     psc_next;
  logic                      cnt_tick;
  logic                      out_latch_reg;
  logic [DCTP_EV_W-1:0]      irq_status_reg;
  logic [DCTP_EV_W-1:0]      irq_mask_reg;
  logic                      wr_en;
  logic                      rd_en;
  logic                      zero_event;
  dctp_mode_t                mode;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;

  // Mode decode from direction and data bits.
  always_comb
  begin
    if (ctrl_reg.pin_direction_out)
      mode = DCTP_MODE_OUTPUT;
    else if (ctrl_reg.pin_data)
      mode = DCTP_MODE_GATED;
    else
      mode = DCTP_MODE_EVENT;
  end

  // Internal clock divided by twelve.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      div_reg <= 4'h0_0;
    else if (fint_tick)
      div_reg <= 4'h0_0;
    else
      div_reg <= div_reg + 4'h0_1;
  end
  assign fint_tick = (div_reg == 4'(FINT_DIV - 1));

  // The edge detector starts high, so a pin held high by its pull-up through
  // reset is not taken as a rising edge; only a later low-to-high step counts.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      pin_prev_reg <= 1'b1;
    else
      pin_prev_reg <= timer_pin_in;
  end
  assign pin_rise = timer_pin_in && !pin_prev_reg;

  // Prescaler clock source per mode.
  always_comb
  begin
    case (mode)
      DCTP_MODE_EVENT:  psc_tick = pin_rise;
      DCTP_MODE_GATED:  psc_tick = fint_tick && timer_pin_in;
      DCTP_MODE_OUTPUT: psc_tick = fint_tick;
      default:          psc_tick = 1'b0;
    endcase
  end

  // A tap clocks the counter on its 0-to-1 transition, which a down count gives
  // when the bits below it all wrap; factor one counts every prescaler tick.
  assign psc_next = prescaler_value_reg - 7'h00_01;
  always_comb
  begin
    if (ctrl_reg.tap_select == 3'h0_0)
      cnt_tick = psc_tick;
    else
      cnt_tick = psc_tick && !prescaler_value_reg[ctrl_reg.tap_select - 3'h0_1]
                 && psc_next[ctrl_reg.tap_select - 3'h0_1];
  end

  // Prescaler.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      prescaler_value_reg <= DCTP_PSC_RST;
    else if (!ctrl_reg.prescaler_run)
      prescaler_value_reg <= DCTP_PSC_RST;
    else if (wr_en && paddr_in == DCTP_ADDR_PSC)
      prescaler_value_reg <= pwdata_in[DCTP_PSC_W-1:0];
    else if (psc_tick)
      prescaler_value_reg <= psc_next;
  end

  // Counter; a software write wins over a coincident decrement.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      down_counter_reg <= DCTP_CNT_RST;
    else if (wr_en && paddr_in == DCTP_ADDR_CNT)
      down_counter_reg <= pwdata_in[DCTP_CNT_W-1:0];
    else if (ctrl_reg.prescaler_run && cnt_tick)
      down_counter_reg <= down_counter_reg - 8'h00_01;
  end

  assign zero_event = ctrl_reg.prescaler_run && cnt_tick
                      && !(wr_en && paddr_in == DCTP_ADDR_CNT)
                      && down_counter_reg == 8'h00_01;

  // Control register; hardware set of the zero flag wins over a clear.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      ctrl_reg <= '0;
    else
    begin
      if (wr_en && paddr_in == DCTP_ADDR_CTRL)
        ctrl_reg <= dctp_ctrl_t'(pwdata_in[7:0]);
      if (zero_event || (wr_en && paddr_in == DCTP_ADDR_CNT
                         && pwdata_in[DCTP_CNT_W-1:0] == DCTP_CNT_ZERO))
        ctrl_reg.zero_flag <= 1'b1;
    end
  end

  // Output latch: transparent while zero flag is high.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      out_latch_reg <= 1'b0;
    else if (ctrl_reg.zero_flag)
      out_latch_reg <= ctrl_reg.pin_data;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      timer_pin_out    <= 1'b0;
      timer_pin_oe_out <= 1'b0;
    end
    else
    begin
      timer_pin_out    <= ctrl_reg.zero_flag ? ctrl_reg.pin_data : out_latch_reg;
      timer_pin_oe_out <= (mode == DCTP_MODE_OUTPUT);
    end
  end

  // Timer interrupt request follows zero flag and enable.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      timer_irq_out <= 1'b0;
    else
      timer_irq_out <= ctrl_reg.zero_flag && ctrl_reg.zero_irq_enable;
  end

  // Sticky status, write one to clear; set wins.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      irq_status_reg <= '0;
    else
    begin
      for (int i = 0; i < DCTP_EV_W; i++)
      begin
        if (wr_en && paddr_in == DCTP_ADDR_IRQS && pwdata_in[i])
          irq_status_reg[i] <= 1'b0;
      end
      if (zero_event)
        irq_status_reg[DCTP_EV_ZERO] <= 1'b1;
      if (pin_rise && mode != DCTP_MODE_OUTPUT)
        irq_status_reg[DCTP_EV_PINEDGE] <= 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      irq_mask_reg <= '0;
    else if (wr_en && paddr_in == DCTP_ADDR_IRQM)
      irq_mask_reg <= pwdata_in[DCTP_EV_W-1:0];
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_status_reg & irq_mask_reg);
  end

  // APB: zero wait state, read data registered in setup phase.
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      prdata_out  <= '0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
      if (psel_in && !penable_in && !pwrite_in)
      begin
        case (paddr_in)
          DCTP_ADDR_CNT:  prdata_out <= {24'h00_0000, down_counter_reg};
          DCTP_ADDR_PSC:  prdata_out <= {25'h000_0000, prescaler_value_reg};
          DCTP_ADDR_CTRL: prdata_out <= {24'h00_0000, ctrl_reg};
          DCTP_ADDR_IRQS: prdata_out <= {30'h0000_0000, irq_status_reg};
          DCTP_ADDR_IRQM: prdata_out <= {30'h0000_0000, irq_mask_reg};
          default:        pslverr_out <= 1'b1;
        endcase
      end
      else if (psel_in && !penable_in)
      begin
        case (paddr_in)
          DCTP_ADDR_CNT, DCTP_ADDR_PSC, DCTP_ADDR_CTRL,
          DCTP_ADDR_IRQS, DCTP_ADDR_IRQM: pslverr_out <= 1'b0;
          default:                        pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  a_stop_forces_psc: assert property (@(posedge clock_in) disable iff (srst_in)
    !ctrl_reg.prescaler_run |=> prescaler_value_reg == DCTP_PSC_RST)
    else $error("Prescaler not forced to all ones while stopped.");

  a_zero_sets_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    zero_event |=> ctrl_reg.zero_flag && down_counter_reg == DCTP_CNT_ZERO)
    else $error("Zero flag not set on countdown to zero.");

  a_irq_follows_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    ctrl_reg.zero_flag && ctrl_reg.zero_irq_enable |=> timer_irq_out)
    else $error("Timer interrupt not raised.");

  a_write_wins_count: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_en && paddr_in == DCTP_ADDR_CNT |=> down_counter_reg == $past(pwdata_in[7:0]))
    else $error("Counter write lost.");

  a_count_one_step: assert property (@(posedge clock_in) disable iff (srst_in)
    $changed(down_counter_reg) && !$past(wr_en) |->
      down_counter_reg == $past(down_counter_reg) - 8'h00_01)
    else $error("Counter moved by other than one.");

  a_gated_pin_low: assert property (@(posedge clock_in) disable iff (srst_in)
    mode == DCTP_MODE_GATED && !timer_pin_in |-> !psc_tick)
    else $error("Gated prescaler ticked with pin low.");

  a_zero_write_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_en && paddr_in == DCTP_ADDR_CNT && pwdata_in[7:0] == DCTP_CNT_ZERO
      |=> ctrl_reg.zero_flag)
    else $error("Writing zero did not set the zero flag.");

  a_pin_latch_drive: assert property (@(posedge clock_in) disable iff (srst_in)
    ctrl_reg.zero_flag |=> timer_pin_out == $past(ctrl_reg.pin_data))
    else $error("Output latch not transparent while zero flag high.");

  a_reset_values: assert property (@(posedge clock_in) srst_in |=>
    down_counter_reg == DCTP_CNT_RST && prescaler_value_reg == DCTP_PSC_RST && ctrl_reg == '0)
    else $error("Reset values not loaded.");

  a_psc_load: assert property (@(posedge clock_in) disable iff (srst_in)
    ctrl_reg.prescaler_run && wr_en && paddr_in == DCTP_ADDR_PSC
      |=> prescaler_value_reg == $past(pwdata_in[DCTP_PSC_W-1:0]))
    else $error("Prescaler load lost while running.");

  a_psc_step: assert property (@(posedge clock_in) disable iff (srst_in)
    ctrl_reg.prescaler_run && psc_tick && !(wr_en && paddr_in == DCTP_ADDR_PSC)
      |=> prescaler_value_reg == $past(psc_next))
    else $error("Prescaler did not step down by one.");

  a_stop_holds_count: assert property (@(posedge clock_in) disable iff (srst_in)
    !ctrl_reg.prescaler_run && !(wr_en && paddr_in == DCTP_ADDR_CNT)
      |=> $stable(down_counter_reg))
    else $error("Counter moved while stopped.");

  a_event_pin_tick: assert property (@(posedge clock_in) disable iff (srst_in)
    mode == DCTP_MODE_EVENT |-> psc_tick == pin_rise)
    else $error("Event mode prescaler not clocked by pin edges.");

  a_output_fint_tick: assert property (@(posedge clock_in) disable iff (srst_in)
    mode == DCTP_MODE_OUTPUT |-> psc_tick == fint_tick)
    else $error("Output mode prescaler not clocked by divided clock.");

  a_output_drives_oe: assert property (@(posedge clock_in) disable iff (srst_in)
    ctrl_reg.pin_direction_out |=> timer_pin_oe_out)
    else $error("Pin not driven in output mode.");

  a_tap_one_tick: assert property (@(posedge clock_in) disable iff (srst_in)
    ctrl_reg.tap_select == 3'h0_1 && psc_tick |-> cnt_tick == !prescaler_value_reg[0])
    else $error("Factor two tap did not follow prescaler bit 0.");

  a_ctrl_sets_flag: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_en && paddr_in == DCTP_ADDR_CTRL && pwdata_in[DCTP_B_ZERO] |=> ctrl_reg.zero_flag)
    else $error("Setting control bit 7 did not set the zero flag.");

  a_write_keeps_clear: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_en && paddr_in == DCTP_ADDR_CNT && pwdata_in[DCTP_CNT_W-1:0] != DCTP_CNT_ZERO
      && !ctrl_reg.zero_flag |=> !ctrl_reg.zero_flag)
    else $error("Zero flag set by a nonzero counter write.");

  a_zero_sets_status: assert property (@(posedge clock_in) disable iff (srst_in)
    zero_event |=> irq_status_reg[DCTP_EV_ZERO])
    else $error("Zero event missing from interrupt status.");

  a_edge_sets_status: assert property (@(posedge clock_in) disable iff (srst_in)
    pin_rise && mode != DCTP_MODE_OUTPUT |=> irq_status_reg[DCTP_EV_PINEDGE])
    else $error("Pin edge missing from interrupt status.");

  a_status_sticky: assert property (@(posedge clock_in) disable iff (srst_in)
    irq_status_reg[DCTP_EV_ZERO] && !(wr_en && paddr_in == DCTP_ADDR_IRQS)
      |=> irq_status_reg[DCTP_EV_ZERO])
    else $error("Zero status bit lost without a clear.");

  a_irq_level: assert property (@(posedge clock_in) disable iff (srst_in)
    |(irq_status_reg & irq_mask_reg) |=> irq_out)
    else $error("Unmasked status did not raise the interrupt.");

  a_ready_pulse: assert property (@(posedge clock_in) disable iff (srst_in)
    psel_in && !penable_in |=> pready_out)
    else $error("Bus setup cycle not answered.");

endmodule : dctp_timer

// ### verification/dctp_pin_model.sv
`timescale 1ns/1ps
module dctp_pin_model
(
  // Bench side.
  input  wire logic drive_en_in,
  input  wire logic level_in,
  // Device side.
  input  wire logic pin_drive_in,
  input  wire logic pin_oe_in,
  output logic      pin_level_out
);
  // The pin has a pull-up, so a released pin reads high rather than holding a stale level.
  always_comb
  begin
    if (pin_oe_in)
      pin_level_out = pin_drive_in;
    else if (drive_en_in)
      pin_level_out = level_in;
    else
      pin_level_out = 1'b1;
  end
endmodule : dctp_pin_model

// ### verification/test_down_counter_timer_prescaler.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_down_counter_timer_prescaler;
  import dctp_pkg::*;
  logic        clock_in, srst_in, psel, pen, pwr, drv_en, lvl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pin_out, pin_oe, pin_lvl, tirq, irq, err;
  int          n_mismatch, samples_checked;

  dctp_timer #(.FINT_DIV(2)) dut_u
  (
    .clock_in(clock_in), .srst_in(srst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .timer_pin_in(pin_lvl),
    .timer_pin_out(pin_out), .timer_pin_oe_out(pin_oe), .timer_irq_out(tirq),
    .irq_out(irq)
  );
  dctp_pin_model pin_u
  (
    .drive_en_in(drv_en), .level_in(lvl), .pin_drive_in(pin_out),
    .pin_oe_in(pin_oe), .pin_level_out(pin_lvl)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : idle

  // Entered just after a rising edge; leaves one idle edge so strobes never double up.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock_in);
    pen <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clock_in);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    err = pslverr;
    if (i == 16)
    begin
      n_mismatch++;
      wrap_up();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_in);
  endtask : apb

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] ex);
    apb(1'b0, a, 8'h00);
    `CHK(nm, ex, q[7:0])
  endtask : rdchk

  task automatic pulses(input int n);
    repeat (n)
    begin
      lvl <= 1'b1;
      idle(2);
      lvl <= 1'b0;
      idle(2);
    end
    idle(4);
  endtask : pulses

  task automatic t_regs();
    rdchk("counter", DCTP_ADDR_CNT, 8'hFF);
    rdchk("prescaler", DCTP_ADDR_PSC, 8'h7F);
    rdchk("control", DCTP_ADDR_CTRL, 8'h00);
    apb(1'b0, 12'h0_0FC, 8'h00);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, DCTP_ADDR_PSC, 8'h10);
    rdchk("stopped prescaler", DCTP_ADDR_PSC, 8'h7F);
    apb(1'b1, DCTP_ADDR_CNT, 8'h42);
    rdchk("counter load", DCTP_ADDR_CNT, 8'h42);
    apb(1'b1, DCTP_ADDR_CNT, 8'h00);
    rdchk("flag by load", DCTP_ADDR_CTRL, 8'h80);
    apb(1'b1, DCTP_ADDR_CTRL, 8'h00);
    rdchk("flag cleared", DCTP_ADDR_CTRL, 8'h00);
    apb(1'b1, DCTP_ADDR_CTRL, 8'h80);
    rdchk("flag by control", DCTP_ADDR_CTRL, 8'h80);
    apb(1'b1, DCTP_ADDR_CTRL, 8'h00);
  endtask : t_regs

  task automatic t_event();
    apb(1'b1, DCTP_ADDR_CTRL, 8'h48);
    apb(1'b1, DCTP_ADDR_PSC, 8'h20);
    rdchk("prescaler load", DCTP_ADDR_PSC, 8'h20);
    apb(1'b1, DCTP_ADDR_CNT, 8'h03);
    pulses(2);
    `CHK("early irq", 1'b0, tirq)
    rdchk("event count", DCTP_ADDR_CNT, 8'h01);
    pulses(1);
    `CHK("timer irq", 1'b1, tirq)
    rdchk("zero", DCTP_ADDR_CNT, 8'h00);
    rdchk("zero flag", DCTP_ADDR_CTRL, 8'hC8);
    rdchk("live prescaler", DCTP_ADDR_PSC, 8'h1D);
    apb(1'b1, DCTP_ADDR_IRQM, 8'h01);
    idle(2);
    `CHK("unmasked irq", 1'b1, irq)
    rdchk("status", DCTP_ADDR_IRQS, 8'h03);
    apb(1'b1, DCTP_ADDR_IRQM, 8'h00);
    idle(2);
    `CHK("masked irq", 1'b0, irq)
    apb(1'b1, DCTP_ADDR_IRQM, 8'h01);
    apb(1'b1, DCTP_ADDR_IRQS, 8'h03);
    apb(1'b1, DCTP_ADDR_CTRL, 8'h48);
    idle(2);
    `CHK("cleared irq", 1'b0, irq)
    `CHK("serviced irq", 1'b0, tirq)
    rdchk("status clear", DCTP_ADDR_IRQS, 8'h00);
  endtask : t_event

  task automatic t_taps();
    logic [7:0] n;
    for (n = 0; n < 8; n++)
    begin
      apb(1'b1, DCTP_ADDR_CTRL, n);
      apb(1'b1, DCTP_ADDR_CTRL, 8'h08 | n);
      apb(1'b1, DCTP_ADDR_CNT, 8'h05);
      pulses((1 << n) - 1);
      rdchk("before tap", DCTP_ADDR_CNT, 8'h05);
      pulses(1);
      rdchk("tap tick", DCTP_ADDR_CNT, 8'h04);
      rdchk("tap prescaler", DCTP_ADDR_PSC, (8'h7F - (8'h01 << n)) & 8'h7F);
    end
  endtask : t_taps

  task automatic t_gated();
    apb(1'b1, DCTP_ADDR_CTRL, 8'h10);
    apb(1'b1, DCTP_ADDR_CTRL, 8'h18);
    idle(20);
    rdchk("gate closed", DCTP_ADDR_PSC, 8'h7F);
    lvl <= 1'b1;
    idle(20);
    lvl <= 1'b0;
    // Twenty open edges at a divide of two give exactly ten prescaler steps.
    rdchk("gate open", DCTP_ADDR_PSC, 8'h75);
  endtask : t_gated

  task automatic t_output();
    drv_en <= 1'b0;
    apb(1'b1, DCTP_ADDR_CTRL, 8'h38);
    apb(1'b1, DCTP_ADDR_CNT, 8'h00);
    idle(2);
    `CHK("pin enable", 1'b1, pin_oe)
    `CHK("pin high", 1'b1, pin_out)
    apb(1'b1, DCTP_ADDR_CTRL, 8'h28);
    idle(2);
    `CHK("pin held", 1'b1, pin_out)
    apb(1'b1, DCTP_ADDR_CNT, 8'h00);
    idle(2);
    `CHK("pin low", 1'b0, pin_lvl)
  endtask : t_output

  initial
  begin
    srst_in = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    drv_en = 1'b1;
    lvl = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    idle(16);
    srst_in <= 1'b0;
    idle(1);
    t_regs();
    t_event();
    t_taps();
    t_gated();
    t_output();
    wrap_up();
  end
endmodule : test_down_counter_timer_prescaler
